// ==== kwip_pkg.sv ====
// Shared constants, types and helpers for the keyboard wake input block
package kwip_pkg;

  // ==========================================================
  // Geometry
  localparam int NUM_KEYS = 8;
  localparam int NUM_ANALOG = 3;
  localparam int ANALOG_BASE = 5;
  localparam int POL_BASE = 4;
  localparam int NUM_POL = 4;
  localparam int ADDR_W = 5;
  localparam int IRQ_W = 2;

  // ==========================================================
  // Register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_PIN_EN = 5'h04;
  localparam logic [4:0] OFS_DIR = 5'h08;
  localparam logic [4:0] OFS_PULL = 5'h0c;
  localparam logic [4:0] OFS_DATA = 5'h10;
  localparam logic [4:0] OFS_ANALOG = 5'h14;
  localparam logic [4:0] OFS_IRQ_STS = 5'h18;
  localparam logic [4:0] OFS_IRQ_MSK = 5'h1c;

  // ==========================================================
  // Control register field positions
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_IE_BIT = 1;
  localparam int CTRL_ACK_BIT = 2;
  localparam int CTRL_FLAG_BIT = 3;
  localparam int CTRL_POL_LSB = 4;

  // Interrupt status bit positions
  localparam int STS_EDGE_BIT = 0;
  localparam int STS_WAKE_BIT = 1;

  // ==========================================================
  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_ANALOG = 3'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  localparam logic [7:0] RST_PREV = 8'hff;

  // ==========================================================
  // Types
  typedef struct packed {
    logic [3:0] pol;
    logic ie;
    logic mode;
  } kwip_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [7:0] wdata;
  } kwip_bus_req_t;

  localparam kwip_ctrl_t RST_CTRL = '{pol: 4'h0, ie: 1'b0, mode: 1'b0};

  // High where a pin sits at its asserted level for the given polarity
  function automatic logic [7:0] kwip_asserted(input logic [7:0] lvl,
                                               input logic [7:0] pol);
    kwip_asserted = ~(lvl ^ pol);
  endfunction

endpackage

// ==== kwip_avmm_slave.sv ====
// Avalon-MM slave front end with one wait state for every access
`timescale 1ns/1ps
`default_nettype none
module kwip_avmm_slave (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Register file side
  input wire logic [7:0] rd_byte,
  output kwip_pkg::kwip_bus_req_t req
);

  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  wire logic busy;

  // Data is captured in the wait cycle so it stands stable at the accept edge
  assign busy = avs_read | avs_write;
  assign ack_d = busy & ~ack_q;
  assign rdata_d = (avs_read & ~ack_q) ? {24'h000000, rd_byte} : rdata_q;
  assign avs_waitrequest = busy & ~ack_q;
  assign avs_readdata = rdata_q;

  // Only byte lane 0 carries register bits
  assign req = '{wr: avs_write & ack_q & avs_byteenable[0], rd: avs_read & ack_q,
                 addr: avs_address, wdata: avs_writedata[7:0]};

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ==== kwip_key_detect.sv ====
// Synchronous edge and level detector driving the shared key event flag
`timescale 1ns/1ps
`default_nettype none
module kwip_key_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Per-pin inputs
  input wire logic [7:0] key_en,
  input wire logic [7:0] asserted,
  // Control
  input wire logic detect_mode_select,
  input wire logic key_flag_acknowledge,
  // Results
  output logic key_event_flag,
  output logic edge_pulse
);

  logic [7:0] prev_q;
  logic [7:0] prev_d;
  logic flag_q;
  logic flag_d;
  wire logic [7:0] edge_vec;
  wire logic level_hold;

  // Disabled pins count as asserted, so enabling a held pin gives no edge
  assign prev_d = asserted | ~key_en;
  assign edge_vec = key_en & asserted & ~prev_q;
  assign edge_pulse = |edge_vec;
  assign level_hold = detect_mode_select & |(key_en & asserted);
  // Set wins over acknowledge
  assign flag_d = edge_pulse | level_hold | (flag_q & ~key_flag_acknowledge);
  assign key_event_flag = flag_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= kwip_pkg::RST_PREV;
      flag_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

endmodule
`default_nettype wire

// ==== kwip_top.sv ====
// Keyboard wake input block: shared port pins, key detection, registers
// Notes on behaviour
// - Eight key inputs share eight port pins.
// - Key enable forces pin to input.
// - Port pull enable still controls pull resistor.
// - Pin level readable when direction bit is 0.
// - Analogue select disables port, key and pull.
// - Three upper inputs share analogue channels alike.
// - Five lower inputs lack analogue, otherwise alike.
// - Inputs 3..0 fixed falling/low sensitivity.
// - Inputs 7..4 have per-pin polarity select.
// - Rising polarity with pull gives pull-down.
// - One edge-only or edge-and-level mode for all.
// - One shared flag gated by one enable.
// - Enabled asserted input wakes stop and wait.
// - Edge is deasserted then asserted on successive cycles.
// - Edge-only mode: acknowledge clears the flag unless an edge sets it in the same cycle.
// - Level mode: flag held while any enabled input asserted.
// - Deep stop uses asynchronous level wake.
`timescale 1ns/1ps
`default_nettype none
module kwip_top (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Avalon-MM register bus
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Shared pins, bit 7 is the topmost key input
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic [7:0] PULLUP_EN,
  output logic [7:0] PULLDOWN_EN,
  // Analogue converter channel enables for pins 7..5
  output logic [2:0] ANALOG_EN,
  // Low-power mode and wake
  input wire logic DEEP_STOP_MODE,
  input wire logic WAIT_MODE,
  output logic WAKE,
  // Interrupt
  output logic IRQ
);

  // ==========================================================
  // Registers
  kwip_pkg::kwip_ctrl_t ctrl_q;
  kwip_pkg::kwip_ctrl_t ctrl_d;
  logic [7:0] pin_en_q;
  logic [7:0] pin_en_d;
  logic [7:0] dir_q;
  logic [7:0] dir_d;
  logic [7:0] pull_q;
  logic [7:0] pull_d;
  logic [7:0] out_q;
  logic [7:0] out_d;
  logic [2:0] analog_q;
  logic [2:0] analog_d;
  logic [1:0] sts_q;
  logic [1:0] sts_d;
  logic [1:0] msk_q;
  logic [1:0] msk_d;
  logic irq_q;
  logic irq_d;
  logic wake_prev_q;

  // ==========================================================
  // Bus front end
  kwip_pkg::kwip_bus_req_t req;
  logic [7:0] rd_byte;

  kwip_avmm_slave u_bus (
    .clk(CLK),
    .rst(RST),
    .avs_address(AVS_ADDRESS),
    .avs_read(AVS_READ),
    .avs_write(AVS_WRITE),
    .avs_writedata(AVS_WRITEDATA),
    .avs_byteenable(AVS_BYTEENABLE),
    .avs_readdata(AVS_READDATA),
    .avs_waitrequest(AVS_WAITREQUEST),
    .rd_byte(rd_byte),
    .req(req)
  );

  // ==========================================================
  // Address decode
  wire logic wr_ctrl;
  wire logic wr_pin_en;
  wire logic wr_dir;
  wire logic wr_pull;
  wire logic wr_data;
  wire logic wr_analog;
  wire logic wr_sts;
  wire logic wr_msk;

  // One write strobe per register offset
  function automatic logic wr_hit(input kwip_pkg::kwip_bus_req_t r, input logic [4:0] ofs);
    wr_hit = r.wr & (r.addr == ofs);
  endfunction

  assign wr_ctrl = wr_hit(req, kwip_pkg::OFS_CTRL);
  assign wr_pin_en = wr_hit(req, kwip_pkg::OFS_PIN_EN);
  assign wr_dir = wr_hit(req, kwip_pkg::OFS_DIR);
  assign wr_pull = wr_hit(req, kwip_pkg::OFS_PULL);
  assign wr_data = wr_hit(req, kwip_pkg::OFS_DATA);
  assign wr_analog = wr_hit(req, kwip_pkg::OFS_ANALOG);
  assign wr_sts = wr_hit(req, kwip_pkg::OFS_IRQ_STS);
  assign wr_msk = wr_hit(req, kwip_pkg::OFS_IRQ_MSK);

  // ==========================================================
  // Pin ownership
  wire logic [7:0] analog_pin;
  wire logic [7:0] key_en;
  wire logic [7:0] pol_full;
  wire logic [7:0] asserted;
  wire logic [7:0] pull_on;

  // Only the three upper pins can be taken by the converter
  assign analog_pin = {analog_q, 5'b00000};
  assign ANALOG_EN = analog_q;
  // Converter ownership overrides the key enable
  assign key_en = pin_en_q & ~analog_pin;
  // Lower four polarities are hard wired to falling/low
  assign pol_full = {ctrl_q.pol, 4'h0};
  assign asserted = kwip_pkg::kwip_asserted(PIN_IN, pol_full);

  // Key input forces the driver off whatever the direction bit says
  assign PIN_OE = dir_q & ~pin_en_q & ~analog_pin;
  assign PIN_OUT = out_q;

  // Pull on for an input pin whose pull enable is set
  assign pull_on = pull_q & ~analog_pin & (pin_en_q | ~dir_q);
  assign PULLUP_EN = pull_on & ~(pin_en_q & pol_full);
  assign PULLDOWN_EN = pull_on & pin_en_q & pol_full;

  // ==========================================================
  // Detection
  logic key_event_flag;
  logic edge_pulse;
  wire logic key_flag_acknowledge;

  assign key_flag_acknowledge = wr_ctrl & req.wdata[kwip_pkg::CTRL_ACK_BIT];

  kwip_key_detect u_detect (
    .clk(CLK),
    .rst(RST),
    .key_en(key_en),
    .asserted(asserted),
    .detect_mode_select(ctrl_q.mode),
    .key_flag_acknowledge(key_flag_acknowledge),
    .key_event_flag(key_event_flag),
    .edge_pulse(edge_pulse)
  );

  // ==========================================================
  // Wake
  wire logic stop_wake;
  wire logic wait_wake;

  // Clocks are gone in deep stop, so this path uses no flip-flop
  assign stop_wake = DEEP_STOP_MODE & |(key_en & asserted);
  // In wait mode the pending key flag wakes the core, even when polled
  assign wait_wake = WAIT_MODE & (key_event_flag | |(key_en & asserted));
  assign WAKE = stop_wake | wait_wake;

  // ==========================================================
  // Read multiplexer
  wire logic [7:0] ctrl_rd;
  wire logic [7:0] data_rd;

  // Acknowledge always reads back as zero
  assign ctrl_rd = {ctrl_q.pol, key_event_flag, 1'b0, ctrl_q.ie, ctrl_q.mode};
  // Direction-0 pins show the pin, direction-1 pins the latch (even key-enabled ones), analogue pins zero
  assign data_rd = ((dir_q & out_q) | (~dir_q & PIN_IN)) & ~analog_pin;

  always_comb begin
    case (req.addr)
      kwip_pkg::OFS_CTRL: rd_byte = ctrl_rd;
      kwip_pkg::OFS_PIN_EN: rd_byte = pin_en_q;
      kwip_pkg::OFS_DIR: rd_byte = dir_q;
      kwip_pkg::OFS_PULL: rd_byte = pull_q;
      kwip_pkg::OFS_DATA: rd_byte = data_rd;
      kwip_pkg::OFS_ANALOG: rd_byte = {5'b00000, analog_q};
      kwip_pkg::OFS_IRQ_STS: rd_byte = {6'b000000, sts_q};
      kwip_pkg::OFS_IRQ_MSK: rd_byte = {6'b000000, msk_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // ==========================================================
  // Next-state values
  wire logic [1:0] sts_set;
  wire logic wake_rise;

  assign wake_rise = WAKE & ~wake_prev_q;
  assign sts_set = {wake_rise, edge_pulse};

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d.mode = req.wdata[kwip_pkg::CTRL_MODE_BIT];
      ctrl_d.ie = req.wdata[kwip_pkg::CTRL_IE_BIT];
      ctrl_d.pol = req.wdata[kwip_pkg::CTRL_POL_LSB +: kwip_pkg::NUM_POL];
    end
  end

  assign pin_en_d = wr_pin_en ? req.wdata : pin_en_q;
  assign dir_d = wr_dir ? req.wdata : dir_q;
  assign pull_d = wr_pull ? req.wdata : pull_q;
  assign out_d = wr_data ? req.wdata : out_q;
  assign analog_d = wr_analog ? req.wdata[2:0] : analog_q;
  // Hardware set wins over a write-one clear in the same cycle
  assign sts_d = (sts_q & ~(wr_sts ? req.wdata[1:0] : 2'b00)) | sts_set;
  assign msk_d = wr_msk ? req.wdata[1:0] : msk_q;
  assign irq_d = (key_event_flag & ctrl_q.ie) | |(sts_q & msk_q);

  // ==========================================================
  // State
  // One short process per register keeps each reset value beside its update
  always_ff @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= kwip_pkg::RST_CTRL;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pin_en_q <= kwip_pkg::RST_BYTE;
    end else begin
      pin_en_q <= pin_en_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      dir_q <= kwip_pkg::RST_BYTE;
    end else begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      pull_q <= kwip_pkg::RST_BYTE;
    end else begin
      pull_q <= pull_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      out_q <= kwip_pkg::RST_BYTE;
    end else begin
      out_q <= out_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      analog_q <= kwip_pkg::RST_ANALOG;
    end else begin
      analog_q <= analog_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      sts_q <= kwip_pkg::RST_IRQ;
    end else begin
      sts_q <= sts_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      msk_q <= kwip_pkg::RST_IRQ;
    end else begin
      msk_q <= msk_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      wake_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= WAKE;
    end
  end

  assign IRQ = irq_q;

endmodule
`default_nettype wire

// ==== kwip_top_sva.sv ====
// Port-level assertions for the keyboard wake input block
`timescale 1ns/1ps
`default_nettype none
module kwip_top_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register bus
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Pins, power and interrupt
  input wire logic [7:0] PIN_OE,
  input wire logic [7:0] PULLUP_EN,
  input wire logic [7:0] PULLDOWN_EN,
  input wire logic [2:0] ANALOG_EN,
  input wire logic DEEP_STOP_MODE,
  input wire logic WAIT_MODE,
  input wire logic WAKE,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ==========================================================
  // Bus handshake
  sequence s_open;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_done;
    !AVS_WAITREQUEST;
  endsequence
  a_one_wait: assert property (s_open |=> s_done) else $error("wait not one cycle");
  a_upper_zero: assert property (AVS_READDATA[31:8] == 24'h000000) else $error("upper bits set");
  // ==========================================================
  // Pin ownership and pulls
  a_reset_quiet: assert property (disable iff (1'b0) $fell(RST) |->
    IRQ == 1'b0 && ANALOG_EN == 3'h0 && PIN_OE == 8'h00 && PULLUP_EN == 8'h00)
    else $error("outputs not cleared by reset");
  a_pull_excl: assert property ((PULLUP_EN & PULLDOWN_EN) == 8'h00)
    else $error("pull-up and pull-down together");
  a_low_nodown: assert property (PULLDOWN_EN[3:0] == 4'h0)
    else $error("pull-down on fixed pin");
  a_analog_off: assert property (({ANALOG_EN, 5'h00} & (PIN_OE | PULLUP_EN | PULLDOWN_EN)) == 8'h00)
    else $error("analog pin still used");
  a_drive_nopull: assert property ((PIN_OE & (PULLUP_EN | PULLDOWN_EN)) == 8'h00)
    else $error("driven pin has a pull");
  // ==========================================================
  // Wake and interrupt
  a_wake_idle: assert property (!DEEP_STOP_MODE && !WAIT_MODE |-> !WAKE)
    else $error("wake while running");
  // Flag and status only clear on a bus write
  a_irq_fall: assert property ($fell(IRQ) |-> $past(AVS_WRITE && !AVS_WAITREQUEST, 2))
    else $error("interrupt fell without write");
endmodule
bind kwip_top kwip_top_chk u_chk (.CLK(CLK), .RST(RST), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .PIN_OE(PIN_OE), .PULLUP_EN(PULLUP_EN), .PULLDOWN_EN(PULLDOWN_EN), .ANALOG_EN(ANALOG_EN),
  .DEEP_STOP_MODE(DEEP_STOP_MODE), .WAIT_MODE(WAIT_MODE), .WAKE(WAKE), .IRQ(IRQ));
`default_nettype wire

// ==== kwip_keypad.sv ====
// Keypad switches and pin wiring on the far side of the shared pins
`timescale 1ns/1ps
`default_nettype none
module kwip_keypad (
  // Clock
  input wire logic clk,
  // Device side
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pull_up,
  input wire logic [7:0] pull_dn,
  // Switch side
  input wire logic [7:0] key_drive,
  input wire logic [7:0] key_level,
  output logic [7:0] pin_level
);
  logic [7:0] float_q;
  initial float_q = 8'h00;
  // A floating pin wanders, so a stale level is never read as valid
  always @(posedge clk) begin
    float_q <= ~float_q;
  end
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin
        pin_level[i] = pin_out[i];
      end else if (key_drive[i]) begin
        pin_level[i] = key_level[i];
      end else if (pull_up[i] | pull_dn[i]) begin
        pin_level[i] = pull_up[i];
      end else begin
        pin_level[i] = float_q[i];
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_keyboard_wake_input_pins.sv ====
// Self-checking bench for the keyboard wake input block
`timescale 1ns/1ps
`default_nettype none
module tb_keyboard_wake_input_pins;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic dstop = 1'b0;
  logic wmode = 1'b0;
  logic [4:0] adr = 5'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] kdrv = 8'h00;
  logic [7:0] klvl = 8'h00;
  logic [31:0] rdata, got;
  logic wreq, wake, irq;
  logic [7:0] pin_in, pin_out, oe, pu, pd, ke, dir, pe, lat;
  logic [3:0] pol;
  logic [2:0] an, asel;
  int err_count = 0;
  int n_compared = 0;
  // ==========================================================
  // Clock, device and pin model
  always #4 CLK = ~CLK;
  kwip_top i_dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA({24'h000000, wd}), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(wreq), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(oe), .PULLUP_EN(pu),
    .PULLDOWN_EN(pd), .ANALOG_EN(an), .DEEP_STOP_MODE(dstop), .WAIT_MODE(wmode),
    .WAKE(wake), .IRQ(irq));
  kwip_keypad i_pad (.clk(CLK), .pin_out(pin_out), .pin_oe(oe), .pull_up(pu), .pull_dn(pd),
    .key_drive(kdrv), .key_level(klvl), .pin_level(pin_in));
  // ==========================================================
  // Helpers
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // Starts after an edge, so a released strobe never rises in the same step
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge CLK);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge CLK);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e, input string what);
    bus(1'b0, a, 8'h00);
    chk(got, {24'h000000, e}, what);
  endtask
  function automatic logic [23:0] pins_exp(input logic [7:0] k, d, p, input logic [3:0] s,
                                           input logic [2:0] a);
    logic [7:0] on;
    on = p & ~{a, 5'h00} & (k | ~d);
    pins_exp = {d & ~k & ~{a, 5'h00}, on & ~(k & {s, 4'h0}), on & k & {s, 4'h0}};
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'h68f8d497));
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      if (a != 4) rchk(5'(a * 4), 8'h00, "reset value");
    end
    rchk(5'h01, 8'h00, "unmapped");
    $display("test reset done");
    for (int n = 0; n < 12; n++) begin
      ke = 8'($urandom);
      dir = 8'($urandom);
      pe = 8'($urandom);
      lat = 8'($urandom);
      pol = 4'($urandom);
      asel = 3'($urandom);
      bus(1'b1, kwip_pkg::OFS_PIN_EN, ke);
      bus(1'b1, kwip_pkg::OFS_DIR, dir);
      bus(1'b1, kwip_pkg::OFS_PULL, pe);
      bus(1'b1, kwip_pkg::OFS_DATA, lat);
      bus(1'b1, kwip_pkg::OFS_CTRL, {pol, 4'h0});
      bus(1'b1, kwip_pkg::OFS_ANALOG, {5'h00, asel});
      kdrv <= 8'hff;
      klvl <= 8'($urandom);
      @(negedge CLK);
      chk({8'h00, oe, pu, pd}, {8'h00, pins_exp(ke, dir, pe, pol, asel)}, "pins");
      chk(32'(an), 32'(asel), "analog");
      chk(32'(pin_out), 32'(lat), "latch");
      rchk(kwip_pkg::OFS_DATA, ((dir & lat) | (~dir & klvl)) & ~{asel, 5'h00}, "data");
    end
    $display("test pins done");
    bus(1'b1, kwip_pkg::OFS_ANALOG, 8'h00);
    bus(1'b1, kwip_pkg::OFS_DIR, 8'h00);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      pol = i[0] ? 4'hf : 4'h0;
      klvl <= {~pol, 4'hf};
      bus(1'b1, kwip_pkg::OFS_CTRL, {pol, 4'h2});
      bus(1'b1, kwip_pkg::OFS_PIN_EN, 8'h01 << i);
      bus(1'b1, kwip_pkg::OFS_CTRL, {pol, 4'h6});
      klvl <= {~pol, 4'hf} ^ (8'h01 << i);
      repeat (3) @(posedge CLK);
      rchk(kwip_pkg::OFS_CTRL, {pol, 4'ha}, "flag set");
      @(negedge CLK);
      chk(32'(irq), 32'h1, "irq on");
      bus(1'b1, kwip_pkg::OFS_CTRL, {pol, 4'h6});
      rchk(kwip_pkg::OFS_CTRL, {pol, 4'h2}, "flag ack");
      @(negedge CLK);
      chk(32'(irq), 32'h0, "irq off");
    end
    $display("test edges done");
    @(posedge CLK);
    klvl <= 8'hff;
    bus(1'b1, kwip_pkg::OFS_PIN_EN, 8'h01);
    bus(1'b1, kwip_pkg::OFS_CTRL, 8'h05);
    bus(1'b1, kwip_pkg::OFS_IRQ_STS, 8'h03);
    klvl <= 8'hfe;
    repeat (3) @(posedge CLK);
    bus(1'b1, kwip_pkg::OFS_CTRL, 8'h05);
    rchk(kwip_pkg::OFS_CTRL, 8'h09, "level hold");
    wmode <= 1'b1;
    @(negedge CLK);
    chk(32'(irq), 32'h0, "irq gated");
    chk(32'(wake), 32'h1, "wait wake");
    bus(1'b1, kwip_pkg::OFS_IRQ_MSK, 8'h01);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk(32'(irq), 32'h1, "masked irq");
    bus(1'b1, kwip_pkg::OFS_IRQ_STS, 8'h01);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk(32'(irq), 32'h0, "status clear");
    @(posedge CLK);
    wmode <= 1'b0;
    klvl <= 8'hff;
    bus(1'b1, kwip_pkg::OFS_CTRL, 8'h05);
    rchk(kwip_pkg::OFS_CTRL, 8'h01, "level gone");
    dstop <= 1'b1;
    klvl <= 8'hfe;
    @(negedge CLK);
    chk(32'(wake), 32'h1, "stop wake");
    @(posedge CLK);
    dstop <= 1'b0;
    klvl <= 8'hff;
    $display("test wake done");
    final_report();
  end
endmodule
`default_nettype wire
